// ---- rtl/sfp_flash_seq.sv ----
// page program and software reset sequencer of a serial nor flash
//
// Summary of operation
// R1: accepted reset aborts work, clears latch, suspend, read mode and wrap bits; the code has no suspend, read mode or wrap bits to clear.
// R2: reset happens only when a 66h frame is directly followed by a 99h frame.
// R3: any instruction other than 99h after 66h disarms the reset.
// R4: after reset is accepted, about 30us pass with every instruction ignored; the code still answers status read 05h in that time.
// R5: host should check busy and suspend are clear before the reset pair.
// R6: opcode 5Ah is recognised as the discoverable parameter read.
// R7: every page program is refused unless the write-enable latch is set.
// R8: single-line program frame is opcode 02h, three address bytes, data bytes.
// R9: data past the page end wraps to the start of the same page.
// R10: beyond 256 data bytes only the last 256 are programmed.
// R11: bytes not sent keep their old contents.
// R12: program runs only if select rises on a byte boundary.
// R13: host holds select low from opcode through the last data byte.
// R14: select rise starts timed cycle; progress flag high throughout, then cleared.
// R15: status reads are answered while the program cycle runs.
// R16: write-enable latch is cleared before the program cycle ends.
// R17: a program aimed at a protected page is not executed.
// R18: four-line program needs the quad enable bit; data uses four lines.
// R19: four-line frame is opcode 32h, three address bytes, nibble-wide data.
// R20: opcode F2h behaves exactly as the single-line page program.
// R21: bits are msb first, sampled on rising serial clock while selected.
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_seq #(
  parameter int PROGRAM_CYCLES = sfp_pkg::PROGRAM_CYCLES_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic quadLine0,
  input wire logic quadLine1,
  input wire logic quadLine2,
  input wire logic quadLine3,
  output logic quadLine1Out,
  output logic quadLine1OeN,
  output logic sfdpReadActive,
  input wire logic quadEnableBit,
  input wire logic protectBit0,
  input wire logic protectBit1,
  input wire logic protectBit2,
  input wire logic protectBit3,
  input wire logic protectBit4,
  output logic writeEnableLatch,
  output logic writeInProgressFlag,
  output logic deviceResetting,
  output logic softResetPulse,
  output logic arrayWrite,
  output logic [23:0] arrayAddress,
  output logic [7:0] arrayData
);
  // ----------------------------------------------------------------------
  // link side: serial clock domain
  // ----------------------------------------------------------------------
  logic frameFresh;
  logic frameSeq;
  logic [2:0] bitCnt;
  logic [2:0] byteCnt;
  logic [7:0] shiftReg;
  logic [7:0] opcodeReg;
  logic [23:0] addrReg;
  logic [7:0] pageIdx;
  logic anyData;
  logic [255:0] maskReg;
  logic [2:0] outIdx;
  logic [8:0] statSync1;
  logic [8:0] statSync2;
  logic [8:0] statCore;

  wire [2:0] bitBase = frameFresh ? 3'h0 : bitCnt;
  wire [2:0] byteBase = frameFresh ? 3'h0 : byteCnt;
  wire [1:0] linkHold = statSync2[8:7];
  wire linkQuadEn = statSync2[6];
  wire [7:0] linkStatus = {1'b0, statSync2[4:0], statSync2[5], 1'b0} | 8'(|linkHold);
  wire quadPhase = (opcodeReg == sfp_pkg::OP_QUAD_PAGE_PROGRAM) && linkQuadEn
                   && (byteBase == sfp_pkg::BYTE_DATA); // R18 R19
  wire [3:0] step = quadPhase ? sfp_pkg::STEP_QUAD : sfp_pkg::STEP_SINGLE;
  wire [3:0] bitSum = 4'({1'b0, bitBase} + step);
  wire byteDone = (bitSum == sfp_pkg::BITS_PER_BYTE);
  wire [7:0] shiftNext = quadPhase ? {shiftReg[3:0], quadLine3, quadLine2, quadLine1, quadLine0}
                                   : {shiftReg[6:0], quadLine0}; // R21
  wire opIsProgram = (opcodeReg == sfp_pkg::OP_PAGE_PROGRAM) || (opcodeReg == sfp_pkg::OP_FAST_PAGE_PROGRAM)
                     || (opcodeReg == sfp_pkg::OP_QUAD_PAGE_PROGRAM); // R20
  wire linkIdle = (linkHold == 2'b00);
  wire bufWrite = byteDone && (byteBase == sfp_pkg::BYTE_DATA) && opIsProgram && linkIdle;
  wire statusPhase = !frameFresh && (byteCnt != sfp_pkg::BYTE_OPCODE)
                     && (opcodeReg == sfp_pkg::OP_READ_STATUS); // R15

  // set by select going high, cleared by the first clock of a frame
  always_ff @(posedge serialClk or posedge selectN) begin
    if (selectN) begin
      frameFresh <= 1'b1;
    end else begin
      frameFresh <= 1'b0;
    end
  end

  // core levels enter the link domain through two flops each
  always_ff @(posedge serialClk) begin
    statSync1 <= statCore;
    statSync2 <= statSync1;
  end

  // frame registers hold after select rises so the core can read them
  always_ff @(posedge serialClk or negedge rstn) begin
    if (!rstn) begin
      frameSeq <= 1'b0;
      bitCnt <= 3'h0;
      byteCnt <= 3'h0;
      shiftReg <= 8'h00;
      opcodeReg <= 8'h00;
      addrReg <= 24'h000000;
      pageIdx <= 8'h00;
      anyData <= 1'b0;
    end else begin
      if (frameFresh) begin
        frameSeq <= !frameSeq;
        anyData <= 1'b0;
      end
      bitCnt <= bitSum[2:0];
      shiftReg <= shiftNext;
      if (byteDone) begin
        if (byteBase != sfp_pkg::BYTE_DATA) begin
          byteCnt <= 3'(byteBase + 3'h1);
        end else begin
          byteCnt <= byteBase;
        end
        if (byteBase == sfp_pkg::BYTE_OPCODE) begin
          opcodeReg <= shiftNext;
        end else if (byteBase != sfp_pkg::BYTE_DATA) begin
          addrReg <= {addrReg[15:0], shiftNext};
        end
        if (byteBase == sfp_pkg::BYTE_ADDR_LAST) begin
          pageIdx <= shiftNext;
        end
        if (bufWrite) begin
          pageIdx <= 8'(pageIdx + 8'h01); // R9 R10
          anyData <= 1'b1;
        end
      end else begin
        byteCnt <= byteBase;
      end
    end
  end

  // byte mask: cleared when the address completes, so unsent bytes stay
  always_ff @(posedge serialClk or negedge rstn) begin
    if (!rstn) begin
      maskReg <= '0;
    end else if (byteDone && opIsProgram && linkIdle) begin
      if (byteBase == sfp_pkg::BYTE_ADDR_LAST) begin
        maskReg <= '0; // R11
      end else if (byteBase == sfp_pkg::BYTE_DATA) begin
        maskReg[pageIdx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge serialClk or posedge selectN) begin
    if (selectN) begin
      sfdpReadActive <= 1'b0;
    end else if (byteDone && (byteBase == sfp_pkg::BYTE_OPCODE) && linkIdle) begin
      sfdpReadActive <= (shiftNext == sfp_pkg::OP_READ_SFDP); // R6
    end
  end

  // status bits leave on the falling edge so the host samples them on the rise
  always_ff @(negedge serialClk or posedge selectN) begin
    if (selectN) begin
      quadLine1Out <= 1'b0;
      quadLine1OeN <= 1'b1;
      outIdx <= 3'h0;
    end else if (statusPhase) begin
      quadLine1Out <= linkStatus[3'h7 - outIdx]; // R15
      quadLine1OeN <= 1'b0;
      outIdx <= 3'(outIdx + 3'h1);
    end
  end

  // ----------------------------------------------------------------------
  // core side: reference clock domain
  // ----------------------------------------------------------------------
  sfp_pkg::sfp_state_t stateReg;
  logic selSync1;
  logic selSync2;
  logic selPrev;
  logic seenSeqReg;
  logic armedReg;
  logic [23:0] cntReg;
  logic [8:0] walkIdx;
  logic pendValid;
  logic [7:0] pendIdx;
  logic [15:0] pageBase;
  logic [7:0] rdData;

  wire [4:0] bp = {protectBit4, protectBit3, protectBit2, protectBit1, protectBit0};
  wire frameEnd = selSync2 && !selPrev;
  wire newFrame = frameEnd && (frameSeq != seenSeqReg);
  wire instr = newFrame && (byteCnt != sfp_pkg::BYTE_OPCODE);
  wire whole = instr && (bitCnt == 3'h0); // R12
  wire opIs = whole && (byteCnt == 3'h1);
  wire [9:0] units = bp[4] ? sfp_pkg::UNITS_SECTOR : sfp_pkg::UNITS_BLOCK;
  wire [9:0] unitIdx = bp[4] ? addrReg[21:12] : {4'h0, addrReg[21:16]};
  wire [9:0] protUnits = (bp[2:0] == 3'h0) ? 10'h000 : 10'(10'h001 << (bp[2:0] - 3'h1));
  wire inRegion = bp[3] ? (unitIdx < protUnits) : (unitIdx >= 10'(units - protUnits));
  wire pageProtected = (bp[2:0] == sfp_pkg::BP_ALL) || ((bp[2:0] != 3'h0) && inRegion);
  wire quadOk = (opcodeReg != sfp_pkg::OP_QUAD_PAGE_PROGRAM) || quadEnableBit; // R18
  wire progGo = whole && opIsProgram && anyData && writeEnableLatch // R7 R8 R20
                && !pageProtected && quadOk && (stateReg == sfp_pkg::ST_IDLE); // R17
  wire resetGo = opIs && armedReg && (opcodeReg == sfp_pkg::OP_RESET)
                 && (stateReg != sfp_pkg::ST_RESETTING); // R2
  wire cntLast = (stateReg == sfp_pkg::ST_PROGRAM) ? (cntReg == 24'(PROGRAM_CYCLES - 1))
                                                   : (cntReg == sfp_pkg::RESET_CYCLES - 24'h000001);
  wire walking = (stateReg == sfp_pkg::ST_PROGRAM) && (walkIdx != sfp_pkg::PAGE_END);

  assign statCore = {stateReg == sfp_pkg::ST_RESETTING, writeInProgressFlag, quadEnableBit,
                     writeEnableLatch, bp[4:0]};
  sfp_page_buf u_page_buf (
    .wrClk(serialClk),
    .wrEn(bufWrite),
    .wrAddr(pageIdx),
    .wrData(shiftNext),
    .rdClk(ref_clk),
    .rdEn(clkEn && walking),
    .rdAddr(walkIdx[7:0]),
    .rdData(rdData)
  );

  // select passes two flops before anything in this domain reads it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      selSync1 <= 1'b1;
      selSync2 <= 1'b1;
      selPrev <= 1'b1;
    end else if (clkEn) begin
      selSync1 <= selectN;
      selSync2 <= selSync1;
      selPrev <= selSync2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      seenSeqReg <= 1'b0;
      armedReg <= 1'b0;
    end else if (clkEn && newFrame) begin
      seenSeqReg <= frameSeq;
      if (instr && (stateReg != sfp_pkg::ST_RESETTING)) begin
        armedReg <= opIs && (opcodeReg == sfp_pkg::OP_RESET_ENABLE); // R3
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stateReg <= sfp_pkg::ST_IDLE;
      cntReg <= 24'h000000;
      writeEnableLatch <= sfp_pkg::STATUS_RESET[sfp_pkg::STAT_WEL_BIT];
      writeInProgressFlag <= sfp_pkg::STATUS_RESET[sfp_pkg::STAT_WIP_BIT];
      deviceResetting <= 1'b0;
      softResetPulse <= 1'b0;
      pageBase <= 16'h0000;
    end else if (clkEn) begin
      softResetPulse <= 1'b0;
      cntReg <= 24'(cntReg + 24'h000001);
      if (resetGo) begin
        stateReg <= sfp_pkg::ST_RESETTING; // R1
        cntReg <= 24'h000000;
        writeEnableLatch <= 1'b0;
        writeInProgressFlag <= 1'b0;
        deviceResetting <= 1'b1;
        softResetPulse <= 1'b1;
      end else begin
        case (stateReg)
          sfp_pkg::ST_IDLE: begin
            if (progGo) begin
              stateReg <= sfp_pkg::ST_PROGRAM; // R14
              cntReg <= 24'h000000;
              writeInProgressFlag <= 1'b1;
              writeEnableLatch <= 1'b0; // R16
              pageBase <= addrReg[23:8];
            end else if (opIs && (opcodeReg == sfp_pkg::OP_WRITE_ENABLE)) begin
              writeEnableLatch <= 1'b1;
            end else if (opIs && (opcodeReg == sfp_pkg::OP_WRITE_DISABLE)) begin
              writeEnableLatch <= 1'b0;
            end
          end
          sfp_pkg::ST_PROGRAM: begin
            if (cntLast) begin
              stateReg <= sfp_pkg::ST_IDLE;
              writeInProgressFlag <= 1'b0; // R14
            end
          end
          sfp_pkg::ST_RESETTING: begin
            if (cntLast) begin
              stateReg <= sfp_pkg::ST_IDLE; // R4
              deviceResetting <= 1'b0;
            end
          end
          default: begin
            stateReg <= sfp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // page walk: one buffer read per cycle, marked bytes go to the array
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      walkIdx <= sfp_pkg::PAGE_END;
      pendValid <= 1'b0;
      pendIdx <= 8'h00;
      arrayWrite <= 1'b0;
      arrayAddress <= 24'h000000;
      arrayData <= 8'h00;
    end else if (clkEn) begin
      if (progGo && !resetGo) begin
        walkIdx <= 9'h000;
      end else if (walking && !resetGo) begin
        walkIdx <= 9'(walkIdx + 9'h001);
      end else begin
        walkIdx <= sfp_pkg::PAGE_END;
      end
      pendValid <= walking && !resetGo && maskReg[walkIdx[7:0]]; // R11
      pendIdx <= walkIdx[7:0];
      arrayWrite <= pendValid && !resetGo;
      arrayAddress <= {pageBase, pendIdx}; // R9
      arrayData <= rdData;
    end
  end
endmodule : sfp_flash_seq
`default_nettype wire

// ---- rtl/sfp_pkg.sv ----
// constants shared by the serial flash program and soft reset sequencer
package sfp_pkg;
  // --------------------------------------------------------------------
  // instruction codes
  // --------------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_FAST_PAGE_PROGRAM = 8'hf2;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_READ_SFDP = 8'h5a;
  // --------------------------------------------------------------------
  // frame layout
  // --------------------------------------------------------------------
  localparam logic [2:0] BYTE_OPCODE = 3'h0;
  localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
  localparam logic [2:0] BYTE_DATA = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_QUAD = 4'h4;
  localparam int PAGE_BYTES = 256;
  localparam logic [8:0] PAGE_END = 9'h100;
  // --------------------------------------------------------------------
  // status byte fields and reset values
  // --------------------------------------------------------------------
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_BP_LSB = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // --------------------------------------------------------------------
  // protection geometry (22-bit array, 64 KB blocks or 4 KB sectors)
  // --------------------------------------------------------------------
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [9:0] UNITS_BLOCK = 10'h040;
  localparam logic [9:0] UNITS_SECTOR = 10'h400;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PROGRAM_CYCLE_TIME_US = 600;
  localparam int RESET_TIME_US = 30;
  localparam int PROGRAM_CYCLES_DEFAULT = PROGRAM_CYCLE_TIME_US * CLK_FREQ_MHZ;
  localparam logic [23:0] RESET_CYCLES = 24'(RESET_TIME_US * CLK_FREQ_MHZ);
  // --------------------------------------------------------------------
  // sequencer states, gray along idle -> program and program -> reset
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROGRAM = 2'b01,
    ST_RESETTING = 2'b11
  } sfp_state_t;
endpackage : sfp_pkg

// ---- rtl/sfp_page_buf.sv ----
// page buffer: written on the serial clock, read on the system clock
`timescale 1ns/100ps
`default_nettype none
module sfp_page_buf (
  input wire logic wrClk,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic rdClk,
  input wire logic rdEn,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:sfp_pkg::PAGE_BYTES-1];

  always_ff @(posedge wrClk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // reads happen only after the frame ended, so the word is stable
  always_ff @(posedge rdClk) begin
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : sfp_page_buf
`default_nettype wire

// ---- verif/sfp_flash_seq_sva.sv ----
// assertions on the ports of the program and soft reset sequencer
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_seq_sva #(
  parameter int PROGRAM_CYCLES = 400
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic selectN,
  input wire logic quadLine1OeN,
  input wire logic sfdpReadActive,
  input wire logic writeEnableLatch,
  input wire logic writeInProgressFlag,
  input wire logic deviceResetting,
  input wire logic softResetPulse,
  input wire logic arrayWrite,
  input wire logic [23:0] arrayAddress
);
  // ------------------------------------------------------------------
  // helper counters: cycles spent busy and resetting
  // ------------------------------------------------------------------
  logic [15:0] wipCnt;
  logic [15:0] rstCnt;
  // counts assume the core is never frozen during a busy spell
  always_ff @(posedge ref_clk) begin
    wipCnt <= (rstn && writeInProgressFlag) ? wipCnt + 16'h1 : 16'h0;
    rstCnt <= (rstn && deviceResetting) ? rstCnt + 16'h1 : 16'h0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_wip_len;
    $fell(writeInProgressFlag) && !deviceResetting |-> wipCnt == 16'(PROGRAM_CYCLES);
  endproperty
  a_wip_len: assert property (p_wip_len) else $error("program cycle length wrong");
  property p_rst_len;
    $fell(deviceResetting) |-> rstCnt == 16'(sfp_pkg::RESET_CYCLES);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset period length wrong");
  property p_latch_busy;
    writeInProgressFlag |-> !writeEnableLatch;
  endproperty
  a_latch_busy: assert property (p_latch_busy) else $error("latch set while busy");
  property p_write_busy;
    arrayWrite |-> writeInProgressFlag && !deviceResetting;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("array write outside program");
  property p_write_slot;
    arrayWrite |-> arrayAddress[7:0] == 8'(wipCnt - 16'h2) && wipCnt <= 16'h101;
  endproperty
  a_write_slot: assert property (p_write_slot) else $error("array write index out of slot");
  property p_page_hold;
    arrayWrite && $past(arrayWrite) |-> arrayAddress[23:8] == $past(arrayAddress[23:8]);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed within program");
  property p_reset_effect;
    softResetPulse |-> deviceResetting && !writeInProgressFlag && !writeEnableLatch ##1 !softResetPulse;
  endproperty
  a_reset_effect: assert property (p_reset_effect) else $error("reset pulse effects wrong");
  property p_reset_quiet;
    deviceResetting |-> !writeEnableLatch && !arrayWrite;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("activity while resetting");
  property p_idle_lines;
    selectN && $past(selectN) && $past(selectN, 2) |-> quadLine1OeN && !sfdpReadActive;
  endproperty
  a_idle_lines: assert property (p_idle_lines) else $error("output active while deselected");
endmodule : sfp_flash_seq_sva
bind sfp_flash_seq sfp_flash_seq_sva #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) sfp_flash_seq_sva_i (
  .ref_clk, .rstn, .selectN, .quadLine1OeN, .sfdpReadActive, .writeEnableLatch,
  .writeInProgressFlag, .deviceResetting, .softResetPulse, .arrayWrite, .arrayAddress
);
`default_nettype wire

// ---- verif/sfp_host_model.sv ----
// host serial controller model driving frames into the sequencer
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
  output logic serialClk,
  output logic selectN,
  output wire logic quadLine0,
  output wire logic quadLine1,
  output wire logic quadLine2,
  output wire logic quadLine3,
  input wire logic quadLine1Out,
  input wire logic quadLine1OeN
);
  logic [3:0] lines;
  logic hostLine1;
  assign {quadLine3, quadLine2, hostLine1, quadLine0} = lines;
  // the device owns the shared line only while its enable is low
  assign quadLine1 = quadLine1OeN ? hostLine1 : quadLine1Out;
  // clock idles low and stands still between frames
  initial begin
    serialClk = 1'b0;
    selectN <= 1'b1;
    lines = 4'h0;
  end
  task automatic tick(input logic [3:0] v, inout logic [15:0] rd);
    lines = v;
    #7.5 serialClk = 1'b1;
    rd = {rd[14:0], quadLine1};
    #7.5 serialClk = 1'b0;
  endtask : tick
  task automatic put(input logic [7:0] b, input bit quad, inout logic [15:0] rd);
    int i;
    if (quad) begin
      tick(b[7:4], rd);
      tick(b[3:0], rd);
    end else begin
      // unused lines toggle so they never look held
      for (i = 7; i >= 0; i--) tick({~lines[3:1], b[i]}, rd);
    end
  endtask : put
  task automatic frame(input logic [7:0] op, input int nAddr, input logic [23:0] addr, input int nData,
                       input bit quad, input int extra, output logic [15:0] rd);
    int k;
    rd = 16'h0;
    selectN = 1'b0;
    #10;
    put(op, 1'b0, rd);
    for (k = 0; k < nAddr; k++) put(addr[8 * (2 - k) +: 8], 1'b0, rd);
    for (k = 0; k < nData; k++) put(8'(k * 3 + (k >> 8)), quad, rd);
    // stray clocks past the last byte, also for read back
    for (k = 0; k < extra; k++) tick(~lines, rd);
    #10;
    selectN = 1'b1;
    lines = ~lines;
    #50;
  endtask : frame
endmodule : sfp_host_model
`default_nettype wire

// ---- verif/sfp_flash_seq_test.sv ----
// self-checking testbench of the program and soft reset sequencer
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_seq_test;
  localparam int PC = 400;
  typedef struct packed {
    logic [7:0] op;
    logic write_enable_latch;
    logic qe;
    logic [4:0] bp;
    logic [23:0] addr;
    logic [8:0] n;
    logic [8:0] exp;
  } sfp_row_t;
  logic ref_clk, rstn, clkEn, quadEnableBit;
  logic [4:0] bp;
  wire logic serialClk, selectN, quadLine0, quadLine1, quadLine2, quadLine3;
  logic quadLine1Out, quadLine1OeN, sfdpReadActive, writeEnableLatch, writeInProgressFlag;
  logic deviceResetting, softResetPulse, arrayWrite;
  logic [23:0] arrayAddress;
  logic [7:0] arrayData, ix;
  logic [7:0] mem [256];
  logic [15:0] pageSeen, rd;
  int nWr = 0, nPulse = 0, nSfdp = 0, nMismatch = 0, cmpCount = 0, w0, p0, r;
  sfp_row_t rows [9] = '{
    '{8'h02, 1'b1, 1'b0, 5'h00, 24'h123400, 9'h004, 9'h004}, '{8'h02, 1'b0, 1'b0, 5'h00, 24'h123400, 9'h004, 9'h000},
    '{8'hf2, 1'b1, 1'b0, 5'h00, 24'h123500, 9'h002, 9'h002}, '{8'hf2, 1'b0, 1'b0, 5'h00, 24'h123500, 9'h002, 9'h000},
    '{8'h32, 1'b1, 1'b1, 5'h00, 24'h123610, 9'h003, 9'h003}, '{8'h32, 1'b1, 1'b0, 5'h00, 24'h123610, 9'h003, 9'h000},
    '{8'h02, 1'b1, 1'b0, 5'h07, 24'h123400, 9'h001, 9'h000}, '{8'h02, 1'b1, 1'b0, 5'h01, 24'h3f0100, 9'h001, 9'h000},
    '{8'h02, 1'b1, 1'b0, 5'h01, 24'h001200, 9'h002, 9'h002}};
  sfp_flash_seq #(.PROGRAM_CYCLES(PC)) sfp_flash_seq_i (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .serialClk(serialClk), .selectN(selectN),
    .quadLine0(quadLine0), .quadLine1(quadLine1), .quadLine2(quadLine2), .quadLine3(quadLine3),
    .quadLine1Out(quadLine1Out), .quadLine1OeN(quadLine1OeN), .sfdpReadActive(sfdpReadActive),
    .quadEnableBit(quadEnableBit), .protectBit0(bp[0]), .protectBit1(bp[1]), .protectBit2(bp[2]),
    .protectBit3(bp[3]), .protectBit4(bp[4]), .writeEnableLatch(writeEnableLatch),
    .writeInProgressFlag(writeInProgressFlag), .deviceResetting(deviceResetting),
    .softResetPulse(softResetPulse), .arrayWrite(arrayWrite), .arrayAddress(arrayAddress), .arrayData(arrayData));
  sfp_host_model sfp_host_model_i (
    .serialClk(serialClk), .selectN(selectN), .quadLine0(quadLine0), .quadLine1(quadLine1),
    .quadLine2(quadLine2), .quadLine3(quadLine3), .quadLine1Out(quadLine1Out), .quadLine1OeN(quadLine1OeN));
  // ------------------------------------------------------------------
  // clock, monitor and helpers
  // ------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (arrayWrite === 1'b1) begin
      mem[arrayAddress[7:0]] <= arrayData;
      pageSeen <= arrayAddress[23:8];
      nWr <= nWr + 1;
    end
    if (softResetPulse === 1'b1) nPulse <= nPulse + 1;
    if (sfdpReadActive === 1'b1) nSfdp <= nSfdp + 1;
  end
  function automatic logic [7:0] d(input int k);
    return 8'(k * 3 + (k >> 8));
  endfunction : d
  task automatic checkBit(input string what, input logic exp, input logic got);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : checkBit
  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : checkVal
  task automatic send(input logic [7:0] op, input logic [23:0] addr, input int n, input int extra);
    int nAddr;
    nAddr = (op == 8'h02 || op == 8'hf2 || op == 8'h32 || op == 8'h5a) ? 3 : 0;
    sfp_host_model_i.frame(op, nAddr, addr, n, op == 8'h32, extra, rd);
    @(posedge ref_clk);
    #1;
  endtask : send
  task automatic waitQuiet;
    int i;
    for (i = 0; i < 4000 && (writeInProgressFlag === 1'b1 || deviceResetting === 1'b1); i++) @(posedge ref_clk);
    #1;
  endtask : waitQuiet
  task automatic wrapUp;
    $display("mismatches %0d comparisons %0d", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrapUp
  initial begin
    #400000;
    nMismatch++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    wrapUp();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rstn <= 1'b0;
    clkEn = 1'b1;
    quadEnableBit = 1'b0;
    bp = 5'h00;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    checkVal("reset outputs", 32'h1, 32'({writeInProgressFlag, writeEnableLatch, deviceResetting,
             softResetPulse, arrayWrite, sfdpReadActive, quadLine1OeN}));
    for (r = 0; r < 9; r++) begin
      @(posedge ref_clk);
      quadEnableBit <= rows[r].qe;
      bp <= rows[r].bp;
      @(posedge ref_clk);
      if (rows[r].write_enable_latch) send(8'h06, 24'h0, 0, 0);
      w0 = nWr;
      send(rows[r].op, rows[r].addr, rows[r].n, 0);
      checkBit("busy", rows[r].exp != 0, writeInProgressFlag);
      checkBit("latch", rows[r].write_enable_latch && rows[r].exp == 0, writeEnableLatch);
      waitQuiet();
      checkVal("writes", 32'(rows[r].exp), 32'(nWr - w0));
      ix = rows[r].addr[7:0] + 8'(rows[r].n) - 8'h1;
      if (rows[r].exp != 0) checkVal("last byte", 32'(d(rows[r].n - 1)), 32'(mem[ix]));
      send(8'h04, 24'h0, 0, 0);
    end
    @(posedge ref_clk);
    quadEnableBit <= 1'b0;
    bp <= 5'h00;
    send(8'h06, 24'h0, 0, 0);
    w0 = nWr;
    send(8'h02, 24'h0010fe, 3, 0);
    waitQuiet();
    checkVal("wrap writes", 32'h3, 32'(nWr - w0));
    checkVal("wrap byte", 32'(d(2)), 32'(mem[8'h00]));
    checkVal("page end byte", 32'(d(1)), 32'(mem[8'hff]));
    checkVal("wrap page", 32'h10, 32'(pageSeen));
    send(8'h06, 24'h0, 0, 0);
    w0 = nWr;
    send(8'h02, 24'h002000, 258, 0);
    send(8'h05, 24'h0, 0, 16);
    checkVal("status", 32'h1, 32'(rd[7:0]));
    waitQuiet();
    checkVal("long writes", 32'h100, 32'(nWr - w0));
    checkVal("last kept 0", 32'(d(256)), 32'(mem[8'h00]));
    checkVal("last kept 1", 32'(d(257)), 32'(mem[8'h01]));
    send(8'h06, 24'h0, 0, 0);
    w0 = nWr;
    send(8'h02, 24'h004000, 1, 3);
    checkBit("partial busy", 1'b0, writeInProgressFlag);
    checkBit("partial latch", 1'b1, writeEnableLatch);
    checkVal("partial writes", 32'h0, 32'(nWr - w0));
    p0 = nPulse;
    send(8'h66, 24'h0, 0, 0);
    send(8'h99, 24'h0, 0, 0);
    checkBit("resetting", 1'b1, deviceResetting);
    checkBit("reset latch", 1'b0, writeEnableLatch);
    send(8'h06, 24'h0, 0, 0);
    checkBit("ignored enable", 1'b0, writeEnableLatch);
    waitQuiet();
    send(8'h66, 24'h0, 0, 0);
    send(8'h06, 24'h0, 0, 0);
    send(8'h99, 24'h0, 0, 0);
    checkBit("disarmed", 1'b0, deviceResetting);
    checkBit("disarm latch", 1'b1, writeEnableLatch);
    send(8'h02, 24'h005000, 1, 0);
    checkBit("abort busy", 1'b1, writeInProgressFlag);
    send(8'h66, 24'h0, 0, 0);
    send(8'h99, 24'h0, 0, 0);
    checkBit("aborted", 1'b0, writeInProgressFlag);
    waitQuiet();
    checkVal("reset pulses", 32'h2, 32'(nPulse - p0));
    p0 = nSfdp;
    send(8'h5a, 24'h0, 0, 8);
    checkBit("param read seen", 1'b1, nSfdp != p0);
    checkBit("param read idle", 1'b0, sfdpReadActive);
    wrapUp();
  end
endmodule : sfp_flash_seq_test
`default_nettype wire
